// ===== ssfg_consts.svh
`ifndef SSFG_CONSTS_SVH
`define SSFG_CONSTS_SVH
`define SSFG_A_MODE 8'h00
`define SSFG_A_POS_SRC 8'h04
`define SSFG_A_SPD_SRC 8'h08
`define SSFG_A_PWM_SRC 8'h0C
`define SSFG_A_AN1_GAIN 8'h10
`define SSFG_A_AN1_OFS 8'h14
`define SSFG_A_AN1_DIR 8'h18
`define SSFG_A_AN2_GAIN 8'h1C
`define SSFG_A_AN2_OFS 8'h20
`define SSFG_A_AN2_DIR 8'h24
`define SSFG_A_PWM_GAIN 8'h28
`define SSFG_A_PWM_OFS 8'h2C
`define SSFG_A_AUX_SCALE 8'h30
`define SSFG_A_FEED 8'h34
`define SSFG_A_GEAR_MOT 8'h38
`define SSFG_A_GEAR_DRV 8'h3C
`define SSFG_A_ENC_RES 8'h40
`define SSFG_A_VF_NUM 8'h44
`define SSFG_A_VF_DEN 8'h48
`define SSFG_A_SETPOINT 8'h4C
`define SSFG_A_POS_USER 8'h50
`define SSFG_A_VEL_USER 8'h54
`define SSFG_A_RAW1 8'h58
`define SSFG_A_RAW2 8'h5C
`define SSFG_A_DUTY 8'h60
`define SSFG_A_AUX_CNT 8'h64
`define SSFG_GAIN_RST 32'h00010001
`define SSFG_ENC_RES_RST 32'h00001000
`define SSFG_FEED_RST 32'h00001000
`define SSFG_GEAR_RST 32'h00000001
`define SSFG_VF_NUM_RST 32'h00000001
`define SSFG_VF_DEN_RST 32'h00001000
`define SSFG_AN_RAW_MAX 32'h00001388
`define SSFG_PWM_RAW_MAX 32'h00007FFF
`define SSFG_MODE_POS 8'hFE
`define SSFG_MODE_SPD 8'hFD
`define SSFG_SRC_AN1 8'h01
`define SSFG_SRC_AN2 8'h02
`define SSFG_SRC_PWM 8'h07
`define SSFG_SRC_AUX 8'h09
`define SSFG_PWM_SEL_DIG1 8'h01
`define SSFG_LAST_JOB 3'h5
`endif

// ===== ssfg_pkg.sv
package ssfg_pkg;
   typedef enum logic [1:0] {S_ISSUE, S_WAIT} ssfg_st_e;

   typedef struct packed {
      logic busy;
      logic done;
      logic neg;
      logic [5:0] cnt;
      logic [32:0] rem;
      logic [63:0] quo;
      logic [31:0] dvs;
   } ssfg_div_s;

   typedef struct packed {
      ssfg_st_e st;
      logic [2:0] job;
      logic d_start;
      logic signed [63:0] d_dnd;
      logic signed [31:0] d_dvs;
      logic [7:0] mode;
      logic [7:0] pos_src;
      logic [7:0] spd_src;
      logic [7:0] pwm_src;
      logic [31:0] an1_gain;
      logic signed [31:0] an1_ofs;
      logic an1_dir_en;
      logic [31:0] an2_gain;
      logic signed [31:0] an2_ofs;
      logic an2_dir_en;
      logic [31:0] pwm_gain;
      logic signed [31:0] pwm_ofs;
      logic [31:0] aux_scale;
      logic [31:0] feed;
      logic [31:0] gear_mot;
      logic [31:0] gear_drv;
      logic [31:0] vf_num;
      logic [31:0] vf_den;
      logic signed [31:0] raw1;
      logic signed [31:0] raw2;
      logic signed [31:0] duty;
      logic signed [31:0] aux_cnt;
      logic signed [31:0] setpoint;
      logic signed [31:0] pos_user;
      logic signed [31:0] vel_user;
      logic sp_valid;
      logic [31:0] pwm_per_cnt;
      logic [31:0] pwm_hi_cnt;
      logic [31:0] pwm_per;
      logic [31:0] pwm_hi;
      logic [3:0] s1;
      logic [3:0] s2;
      logic dig1_prev;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } ssfg_state_s;
endpackage

// ===== ssfg_div_if.sv
`timescale 1ns/1ps
interface ssfg_div_if;
   logic start;
   logic signed [63:0] dividend;
   logic signed [31:0] divisor;
   logic done;
   logic signed [31:0] quotient;
   modport master (output start, output dividend, output divisor, input done, input quotient);
   modport unit (input start, input dividend, input divisor, output done, output quotient);
endinterface

// ===== ssfg_divider.sv
`timescale 1ns/1ps
module ssfg_divider (
   input wire logic clk,
   input wire logic arst_n,
   ssfg_div_if.unit dv
);
   ssfg_pkg::ssfg_div_s r;
   ssfg_pkg::ssfg_div_s n;
   logic [32:0] sh;

   // Magnitudes are divided and the sign applied last, so the quotient truncates toward zero.
   always_comb begin
      sh = 33'h000000000;
      n = r;
      n.done = 1'b0;
      if (r.busy) begin
         sh = {r.rem[31:0], r.quo[63]};
         n.quo = {r.quo[62:0], 1'b0};
         if (sh >= {1'b0, r.dvs}) begin
            n.rem = sh - {1'b0, r.dvs};
            n.quo[0] = 1'b1;
         end else begin
            n.rem = sh;
         end
         if (r.cnt == 6'h3F) begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end
         n.cnt = r.cnt + 6'h01;
      end else if (dv.start) begin
         n.busy = 1'b1;
         n.cnt = 6'h00;
         n.rem = 33'h000000000;
         n.neg = dv.dividend[63] ^ dv.divisor[31];
         n.quo = dv.dividend[63] ? (~dv.dividend + 64'h0000000000000001) : dv.dividend;
         n.dvs = dv.divisor[31] ? (~dv.divisor + 32'h00000001) : dv.divisor;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // A zero divisor gives zero rather than an all-ones quotient.
   assign dv.done = r.done;
   assign dv.quotient = (r.dvs == 32'h00000000) ? 32'sh00000000 :
                        (r.neg ? -$signed(r.quo[31:0]) : $signed(r.quo[31:0]));
endmodule

// ===== ssfg_top.sv
// Overview of operation
// RQ1: Analog input spanning 0 to 5 V becomes raw value 0 to 5000.
// RQ2: Signed offset is added to the raw value before the gain.
// RQ3: Gain is a numerator over a denominator, output range over input range.
// RQ4: Each analog input has its own gain and offset entry.
// RQ5: Enabled direction input at low level inverts that analog raw value.
// RQ6: PWM duty on the selected input is measured as 0 to 32767.
// RQ7: PWM input has its own offset and gain, applied like analog inputs.
// RQ8: PWM source value 1 selects digital input one for measurement.
// RQ9: Mode -3 is analog speed control, mode -2 analog position control.
// RQ10: Position source 1 and 2 pick analog inputs, 9 the auxiliary counter.
// RQ11: Speed source 7 picks PWM duty, 1 the first analog input.
// RQ12: Stepper source drives pulses on input one and direction on input two.
// RQ13: Auxiliary scaling word holds numerator high and denominator low.
// RQ14: User position is internal times feed over resolution times gear ratio.
// RQ15: Internal speed in rpm is scaled by its own velocity factor.
// RQ16: By default gear ratio is 1:1 and feed equals encoder resolution.
// RQ17: By default the velocity factor is the reciprocal of encoder resolution.
// RQ18: Position monitors and limits use the user position scaling.
// RQ19: Speed monitors, set-points and actual values use the user speed scaling.
// RQ20: Configuring party must redo position limits after changing the scaling.
// RQ21: Scaling multiplies first, then divides, truncating toward zero.
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ssfg_consts.svh"
module ssfg_top #(
   parameter int ADC_W = 12,
   parameter int ADC_FS = 4095
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [ADC_W-1:0] analog_input_one,
   input wire logic [ADC_W-1:0] analog_input_two,
   input wire logic analog_dir_one,
   input wire logic analog_dir_two,
   input wire logic digital_input_one,
   input wire logic digital_input_two,
   input wire logic signed [31:0] pos_internal,
   input wire logic signed [31:0] vel_internal,
   output logic signed [31:0] setpoint,
   output logic setpoint_valid,
   output logic signed [31:0] pos_user,
   output logic signed [31:0] vel_user
);
   localparam ssfg_pkg::ssfg_state_s RST = '{
      st: ssfg_pkg::S_ISSUE,
      an1_gain: `SSFG_GAIN_RST,
      an2_gain: `SSFG_GAIN_RST,
      pwm_gain: `SSFG_GAIN_RST,
      aux_scale: `SSFG_GAIN_RST,
      feed: `SSFG_FEED_RST,
      gear_mot: `SSFG_GEAR_RST,
      gear_drv: `SSFG_GEAR_RST,
      vf_num: `SSFG_VF_NUM_RST,
      vf_den: `SSFG_VF_DEN_RST,
      d_dvs: 32'sh00000001,
      hreadyout: 1'b1,
      default: '0
   };
   localparam logic [31:0] ENC_RES = `SSFG_ENC_RES_RST;

   ssfg_pkg::ssfg_state_s r;
   ssfg_pkg::ssfg_state_s n;
   ssfg_div_if dv ();

   logic signed [63:0] dnd;
   logic signed [31:0] dvs;
   logic rise;
   logic mapped;

   function automatic logic signed [63:0] mul64(input logic signed [31:0] a,
                                                input logic signed [31:0] b);
      return 64'(a) * 64'(b);
   endfunction

   function automatic logic signed [31:0] gnum(input logic [31:0] g);
      return $signed({{16{g[31]}}, g[31:16]}); // see RQ13
   endfunction

   function automatic logic signed [31:0] gden(input logic [31:0] g);
      return $signed({16'h0000, g[15:0]}); // see RQ13
   endfunction

   function automatic logic signed [31:0] u16mul(input logic [31:0] a, input logic [31:0] b);
      return $signed({16'h0000, a[15:0]} * {16'h0000, b[15:0]});
   endfunction

   function automatic logic signed [31:0] shifted(input logic signed [31:0] raw,
                                                  input logic signed [31:0] ofs,
                                                  input logic dir_en,
                                                  input logic dir_lvl);
      logic signed [31:0] v;
      v = (dir_en && !dir_lvl) ? -raw : raw; // see RQ5
      return v + ofs; // see RQ2
   endfunction

   function automatic logic [31:0] rd(input ssfg_pkg::ssfg_state_s s, input logic [7:0] a);
      case (a)
         `SSFG_A_MODE: rd = {24'h000000, s.mode};
         `SSFG_A_POS_SRC: rd = {24'h000000, s.pos_src};
         `SSFG_A_SPD_SRC: rd = {24'h000000, s.spd_src};
         `SSFG_A_PWM_SRC: rd = {24'h000000, s.pwm_src};
         `SSFG_A_AN1_GAIN: rd = s.an1_gain;
         `SSFG_A_AN1_OFS: rd = s.an1_ofs;
         `SSFG_A_AN1_DIR: rd = {31'h00000000, s.an1_dir_en};
         `SSFG_A_AN2_GAIN: rd = s.an2_gain;
         `SSFG_A_AN2_OFS: rd = s.an2_ofs;
         `SSFG_A_AN2_DIR: rd = {31'h00000000, s.an2_dir_en};
         `SSFG_A_PWM_GAIN: rd = s.pwm_gain;
         `SSFG_A_PWM_OFS: rd = s.pwm_ofs;
         `SSFG_A_AUX_SCALE: rd = s.aux_scale;
         `SSFG_A_FEED: rd = s.feed;
         `SSFG_A_GEAR_MOT: rd = s.gear_mot;
         `SSFG_A_GEAR_DRV: rd = s.gear_drv;
         `SSFG_A_ENC_RES: rd = ENC_RES;
         `SSFG_A_VF_NUM: rd = s.vf_num;
         `SSFG_A_VF_DEN: rd = s.vf_den;
         `SSFG_A_SETPOINT: rd = s.setpoint;
         `SSFG_A_POS_USER: rd = s.pos_user;
         `SSFG_A_VEL_USER: rd = s.vel_user;
         `SSFG_A_RAW1: rd = s.raw1;
         `SSFG_A_RAW2: rd = s.raw2;
         `SSFG_A_DUTY: rd = s.duty;
         `SSFG_A_AUX_CNT: rd = s.aux_cnt;
         // Unmapped offsets read as zero rather than aliasing a register.
         default: rd = 32'h00000000;
      endcase
   endfunction

   always_comb begin
      dnd = 64'sh0000000000000000;
      dvs = 32'sh00000001;
      n = r;
      n.sp_valid = 1'b0;
      n.d_start = 1'b0;

      // Only the second stage is read; the first may be metastable.
      n.s1 = {analog_dir_two, analog_dir_one, digital_input_two, digital_input_one};
      n.s2 = r.s1;
      n.dig1_prev = r.s2[0];
      rise = r.s2[0] && !r.dig1_prev;

      // Step pulses count up while the direction level is high, down while it is low.
      if (rise) begin
         n.aux_cnt = r.s2[1] ? (r.aux_cnt + 32'sh00000001) : (r.aux_cnt - 32'sh00000001); // see RQ12
      end

      // One PWM period runs from rising edge to rising edge; duty is taken once per period.
      if (r.pwm_src == `SSFG_PWM_SEL_DIG1) begin // see RQ8
         n.pwm_per_cnt = r.pwm_per_cnt + 32'h00000001;
         if (r.s2[0]) begin
            n.pwm_hi_cnt = r.pwm_hi_cnt + 32'h00000001;
         end
         if (rise) begin
            n.pwm_per = r.pwm_per_cnt;
            n.pwm_hi = r.pwm_hi_cnt;
            n.pwm_per_cnt = 32'h00000001;
            n.pwm_hi_cnt = 32'h00000001;
         end
      end

      // One shared divider saves area; the price is that each result refreshes every 402 cycles.
      // Jobs 0 to 3 multiply full-width words before the divider runs; jobs 4 and 5 keep only the low 16 bits of each scaling word except vf_den.
      case (r.job)
         3'h0: begin
            dnd = mul64($signed(32'(analog_input_one)), `SSFG_AN_RAW_MAX); // see RQ1
            dvs = ADC_FS[31:0];
         end
         3'h1: begin
            dnd = mul64($signed(32'(analog_input_two)), `SSFG_AN_RAW_MAX); // see RQ1
            dvs = ADC_FS[31:0];
         end
         3'h2: begin
            dnd = mul64($signed(r.pwm_hi), `SSFG_PWM_RAW_MAX); // see RQ6
            dvs = $signed(r.pwm_per);
         end
         3'h3: begin
            if (r.mode == `SSFG_MODE_POS) begin // see RQ9
               case (r.pos_src) // see RQ10
                  `SSFG_SRC_AN1: begin
                     dnd = mul64(shifted(r.raw1, r.an1_ofs, r.an1_dir_en, r.s2[2]),
                                 gnum(r.an1_gain)); // see RQ4
                     dvs = gden(r.an1_gain); // see RQ3
                  end
                  `SSFG_SRC_AN2: begin
                     dnd = mul64(shifted(r.raw2, r.an2_ofs, r.an2_dir_en, r.s2[3]),
                                 gnum(r.an2_gain)); // see RQ4
                     dvs = gden(r.an2_gain); // see RQ3
                  end
                  `SSFG_SRC_AUX: begin
                     dnd = mul64(r.aux_cnt, gnum(r.aux_scale)); // see RQ13
                     dvs = gden(r.aux_scale);
                  end
                  default: begin
                     dnd = 64'sh0000000000000000;
                     dvs = 32'sh00000001;
                  end
               endcase
            end else if (r.mode == `SSFG_MODE_SPD) begin // see RQ9
               case (r.spd_src) // see RQ11
                  `SSFG_SRC_AN1: begin
                     dnd = mul64(shifted(r.raw1, r.an1_ofs, r.an1_dir_en, r.s2[2]),
                                 gnum(r.an1_gain)); // see RQ3
                     dvs = gden(r.an1_gain);
                  end
                  `SSFG_SRC_AN2: begin
                     dnd = mul64(shifted(r.raw2, r.an2_ofs, r.an2_dir_en, r.s2[3]),
                                 gnum(r.an2_gain));
                     dvs = gden(r.an2_gain);
                  end
                  `SSFG_SRC_PWM: begin
                     dnd = mul64(shifted(r.duty, r.pwm_ofs, 1'b0, 1'b1),
                                 gnum(r.pwm_gain)); // see RQ7
                     dvs = gden(r.pwm_gain); // see RQ7
                  end
                  default: begin
                     dnd = 64'sh0000000000000000;
                     dvs = 32'sh00000001;
                  end
               endcase
            end
         end
         3'h4: begin
            // Gear ratio is motor over driving revolutions, so driving revs join the feed.
            // Only the low 16 bits of feed, gear and velocity words enter the products.
            dnd = mul64(pos_internal, u16mul(r.feed, r.gear_drv)); // see RQ14
            dvs = u16mul(ENC_RES, r.gear_mot); // see RQ14
         end
         3'h5: begin
            dnd = mul64(vel_internal, u16mul(r.vf_num, ENC_RES)); // see RQ15
            dvs = $signed(r.vf_den); // see RQ15
         end
         default: begin
            dnd = 64'sh0000000000000000;
            dvs = 32'sh00000001;
         end
      endcase

      // Operands freeze at the issue cycle, so an input change shows up one round later.
      case (r.st)
         ssfg_pkg::S_ISSUE: begin
            n.d_start = 1'b1;
            n.d_dnd = dnd;
            n.d_dvs = dvs;
            n.st = ssfg_pkg::S_WAIT;
         end
         ssfg_pkg::S_WAIT: begin
            if (dv.done) begin
               case (r.job)
                  3'h0: n.raw1 = dv.quotient;
                  3'h1: n.raw2 = dv.quotient;
                  3'h2: n.duty = dv.quotient;
                  3'h3: begin
                     n.setpoint = dv.quotient; // see RQ21
                     n.sp_valid = 1'b1;
                  end
                  3'h4: n.pos_user = dv.quotient; // see RQ18
                  3'h5: n.vel_user = dv.quotient; // see RQ19
                  default: n.raw1 = r.raw1;
               endcase
               n.job = (r.job == `SSFG_LAST_JOB) ? 3'h0 : (r.job + 3'h1);
               n.st = ssfg_pkg::S_ISSUE;
            end
         end
         default: n.st = ssfg_pkg::S_ISSUE;
      endcase

      // Zero wait states; read data is fetched in the address phase and held in a flop.
      n.hreadyout = 1'b1;
      n.hresp = 1'b0;
      mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
      if (hsel && hready && htrans[1]) begin
         n.wr_pend = hwrite && mapped;
         n.wr_addr = haddr[7:0];
         n.hrdata = (!hwrite && mapped) ? rd(r, haddr[7:0]) : 32'h00000000;
      end else begin
         n.wr_pend = 1'b0;
      end

      // Read-only words fall to the default branch, so writes to them are dropped.
      if (r.wr_pend) begin
         case (r.wr_addr)
            `SSFG_A_MODE: n.mode = hwdata[7:0];
            `SSFG_A_POS_SRC: n.pos_src = hwdata[7:0];
            `SSFG_A_SPD_SRC: n.spd_src = hwdata[7:0];
            `SSFG_A_PWM_SRC: n.pwm_src = hwdata[7:0];
            `SSFG_A_AN1_GAIN: n.an1_gain = hwdata;
            `SSFG_A_AN1_OFS: n.an1_ofs = hwdata;
            `SSFG_A_AN1_DIR: n.an1_dir_en = hwdata[0];
            `SSFG_A_AN2_GAIN: n.an2_gain = hwdata;
            `SSFG_A_AN2_OFS: n.an2_ofs = hwdata;
            `SSFG_A_AN2_DIR: n.an2_dir_en = hwdata[0];
            `SSFG_A_PWM_GAIN: n.pwm_gain = hwdata;
            `SSFG_A_PWM_OFS: n.pwm_ofs = hwdata;
            `SSFG_A_AUX_SCALE: n.aux_scale = hwdata;
            `SSFG_A_FEED: n.feed = hwdata;
            `SSFG_A_GEAR_MOT: n.gear_mot = hwdata;
            `SSFG_A_GEAR_DRV: n.gear_drv = hwdata;
            `SSFG_A_VF_NUM: n.vf_num = hwdata;
            `SSFG_A_VF_DEN: n.vf_den = hwdata;
            default: n.wr_addr = r.wr_addr;
         endcase
      end
   end

   // Reset gives a 1:1 gear, feed equal to resolution and the reciprocal velocity factor.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= RST; // see RQ16 see RQ17
      end else begin
         r <= n;
      end
   end

   assign dv.start = r.d_start;
   assign dv.dividend = r.d_dnd;
   assign dv.divisor = r.d_dvs;

   ssfg_divider u_div (
      .clk(clk),
      .arst_n(arst_n),
      .dv(dv)
   );

   assign hrdata = r.hrdata;
   assign hreadyout = r.hreadyout;
   assign hresp = r.hresp;
   assign setpoint = r.setpoint;
   assign setpoint_valid = r.sp_valid;
   assign pos_user = r.pos_user;
   assign vel_user = r.vel_user;
endmodule

// ===== ssfg_top_chk.sv
`timescale 1ns/1ps
`include "ssfg_consts.svh"
module ssfg_top_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic signed [31:0] setpoint,
   input wire logic setpoint_valid,
   input wire logic signed [31:0] pos_user,
   input wire logic signed [31:0] vel_user
);
   logic [8:0] gap_reg;
   logic seen_reg;
   logic [7:0] mode_reg;
   logic mode_ph_reg;
   logic rd_go;
   assign rd_go = hsel && hready && htrans[1] && !hwrite && hsize == 3'h2;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // A shadow of the mode byte lets the refusal check work without peeking inside.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gap_reg <= 9'h000;
         seen_reg <= 1'b0;
         mode_reg <= 8'h00;
         mode_ph_reg <= 1'b0;
      end else begin
         gap_reg <= setpoint_valid ? 9'h000 : gap_reg + 9'h001;
         seen_reg <= seen_reg | setpoint_valid;
         mode_ph_reg <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0;
         if (mode_ph_reg) begin
            mode_reg <= hwdata[7:0];
         end
      end
   end
   a_resp_okay: assert property (hresp == 1'b0) else $error("slave gave an error response");
   a_ready_after_reset: assert property ($past(arst_n) |-> hreadyout)
      else $error("slave not ready after reset");
   a_valid_single: assert property (setpoint_valid |=> !setpoint_valid)
      else $error("set-point strobe longer than one cycle");
   a_valid_period: assert property (setpoint_valid && seen_reg |-> gap_reg == 9'h191)
      else $error("set-point strobe period wrong");
   a_valid_not_late: assert property (seen_reg |-> gap_reg <= 9'h191)
      else $error("set-point strobe missing");
   a_bad_mode_zero: assert property (setpoint_valid && mode_reg != `SSFG_MODE_POS &&
      mode_reg != `SSFG_MODE_SPD |-> setpoint == 32'h0) else $error("set-point not zero");
   a_pos_user_slot: assert property ($changed(pos_user) |-> $past(setpoint_valid, 67))
      else $error("user position updated out of turn");
   a_vel_user_slot: assert property ($changed(vel_user) |-> $past(setpoint_valid, 134))
      else $error("user speed updated out of turn");
   a_unmapped_zero: assert property (rd_go && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_res_fixed: assert property (rd_go && haddr == 32'h40 |=> hrdata == `SSFG_ENC_RES_RST)
      else $error("encoder resolution changed");
endmodule

// ===== ssfg_src_model.sv
`timescale 1ns/1ps
module ssfg_src_model (
   input wire logic clk,
   input wire logic pwm_en,
   output logic digital_input_one,
   output logic digital_input_two
);
   int ph = 0;
   initial begin
      digital_input_one = 1'b0;
      digital_input_two = 1'b0;
   end
   // PWM of 25 high cycles in a period of 100.
   always @(posedge clk) begin
      if (pwm_en) begin
         ph <= (ph == 99) ? 0 : ph + 1;
         digital_input_one <= (ph < 25);
      end
   end
   // Direction settles before each pulse, since the pins pass a synchroniser.
   task automatic step(input int n, input logic up);
      repeat (n) begin
         digital_input_two <= up;
         repeat (4) @(posedge clk);
         digital_input_one <= 1'b1;
         repeat (4) @(posedge clk);
         digital_input_one <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule

// ===== ssfg_testbench.sv
`timescale 1ns/1ps
`include "ssfg_consts.svh"
module testbench;
   localparam int FS = 4095;
   localparam logic [31:0] RA [11] = '{32'h0, 32'h10, 32'h1C, 32'h28, 32'h34, 32'h38, 32'h3C,
      32'h40, 32'h44, 32'h48, 32'h100};
   localparam logic [31:0] RV [11] = '{32'h0, 32'h00010001, 32'h00010001, 32'h00010001,
      32'h1000, 32'h1, 32'h1, 32'h1000, 32'h1, 32'h1000, 32'h0};
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [11:0] analog_input_one = 12'h000;
   logic [11:0] analog_input_two = 12'h000;
   logic analog_dir_one = 1'b1;
   logic analog_dir_two = 1'b1;
   logic digital_input_one;
   logic digital_input_two;
   logic signed [31:0] pos_internal = 32'h0;
   logic signed [31:0] vel_internal = 32'h0;
   logic signed [31:0] setpoint;
   logic signed [31:0] pos_user;
   logic signed [31:0] vel_user;
   logic setpoint_valid;
   logic pwm_en = 1'b0;
   logic rd_ph = 1'b0;
   logic [11:0] code;
   logic [31:0] re;
   logic [95:0] se;
   logic signed [31:0] fp = 32'sh1000;
   logic signed [31:0] fd = 32'sh1000;
   logic signed [31:0] vd = 32'sh1000;
   logic signed [31:0] duty;
   logic [31:0] rq[$];
   logic [95:0] sq[$];
   int fails = 0;
   int checks = 0;
   int cyc = 0;
   ssfg_top #(.ADC_W(12), .ADC_FS(FS)) ssfg_top_inst (.hready(hreadyout), .*);
   ssfg_src_model ssfg_src_model_inst (.clk(clk), .pwm_en(pwm_en),
      .digital_input_one(digital_input_one), .digital_input_two(digital_input_two));
   always #2.5 clk = ~clk;
   function automatic logic signed [31:0] scl(input logic signed [31:0] v,
         input logic signed [31:0] n, input logic signed [31:0] d);
      longint p;
      p = longint'(v) * longint'(n);
      return 32'(p / longint'(d));
   endfunction
   function automatic logic signed [31:0] raw_of(input logic [11:0] c);
      return scl($signed({20'h0, c}), 32'sh1388, 32'(FS));
   endfunction
   task automatic test_done();
      if (fails == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      if (!w) begin
         rq.push_back(d);
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      do @(posedge clk); while (hreadyout !== 1'b1);
   endtask
   // Stale results are skipped: three strobes pass before the note is made.
   task automatic expect_out(input logic signed [31:0] sp);
      pos_internal <= $signed(($urandom % 32'h001E8480) - 32'h000F4240);
      vel_internal <= $signed(($urandom % 32'h001E8480) - 32'h000F4240);
      repeat (3) begin
         do @(posedge clk); while (setpoint_valid !== 1'b1);
      end
      @(posedge clk);
      sq.push_back({sp, scl(pos_internal, fp, fd), scl(vel_internal, 32'sh1000, vd)});
      while (sq.size() > 0) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         test_done();
      end
   end
   always @(posedge clk) begin
      if (rd_ph && hreadyout === 1'b1 && rq.size() > 0) begin
         re = rq.pop_front();
         checks++;
         if (hrdata !== re) begin
            fails++;
            $display("unexpected %0t read %h wanted %h", $time, hrdata, re);
         end
      end
      rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
   end
   always @(posedge clk) begin
      if (setpoint_valid === 1'b1 && sq.size() > 0) begin
         se = sq.pop_front();
         checks++;
         if ({setpoint, pos_user, vel_user} !== se) begin
            fails++;
            $display("unexpected %0t outputs %0d %0d %0d", $time, setpoint, pos_user, vel_user);
         end
      end
   end
   initial begin
      void'($urandom(52232));
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      foreach (RA[i]) xfer(1'b0, RA[i], RV[i]);
      xfer(1'b1, 32'h40, 32'h1234);
      xfer(1'b0, 32'h40, 32'h1000);
      expect_out(32'sh0);
      xfer(1'b1, 32'h30, 32'h100003E8);
      xfer(1'b1, 32'h0, 32'hFE);
      xfer(1'b1, 32'h4, 32'h9);
      ssfg_src_model_inst.step(10, 1'b1);
      ssfg_src_model_inst.step(3, 1'b0);
      expect_out(scl(32'sh7, 32'sh1000, 32'sh3E8));
      ssfg_src_model_inst.step(20, 1'b0);
      expect_out(scl(-32'shD, 32'sh1000, 32'sh3E8));
      xfer(1'b1, 32'h10, 32'h10001388);
      xfer(1'b1, 32'h14, 32'hFFFFF63C);
      xfer(1'b1, 32'h4, 32'h1);
      for (int i = 0; i < 4; i++) begin
         code = (i == 0) ? 12'hFFF : 12'($urandom % 32'h1000);
         analog_input_one <= code;
         expect_out(scl(raw_of(code) - 32'sh9C4, 32'sh1000, 32'sh1388));
      end
      xfer(1'b1, 32'h1C, 32'h10001388);
      xfer(1'b1, 32'h24, 32'h1);
      xfer(1'b1, 32'h4, 32'h2);
      code = 12'($urandom % 32'h1000);
      analog_input_two <= code;
      analog_dir_two <= 1'b0;
      expect_out(scl(-raw_of(code), 32'sh1000, 32'sh1388));
      analog_dir_two <= 1'b1;
      expect_out(scl(raw_of(code), 32'sh1000, 32'sh1388));
      xfer(1'b1, 32'h0, 32'hFD);
      xfer(1'b1, 32'h8, 32'h1);
      xfer(1'b1, 32'h10, 32'h17701388);
      expect_out(scl(raw_of(analog_input_one) - 32'sh9C4, 32'sh1770, 32'sh1388));
      xfer(1'b1, 32'hC, 32'h1);
      xfer(1'b1, 32'h2C, 32'hFFFFC000);
      xfer(1'b1, 32'h28, 32'h27106666);
      xfer(1'b1, 32'h8, 32'h7);
      pwm_en <= 1'b1;
      duty = scl(32'sh19, 32'sh7FFF, 32'sh64);
      expect_out(scl(duty - 32'sh4000, 32'sh2710, 32'sh6666));
      xfer(1'b0, 32'h60, duty);
      xfer(1'b1, 32'h34, 32'hE10);
      xfer(1'b1, 32'h38, 32'hE);
      xfer(1'b1, 32'h48, 32'hEA60);
      fp = 32'shE10;
      fd = 32'shE000;
      vd = 32'shEA60;
      expect_out(scl(duty - 32'sh4000, 32'sh2710, 32'sh6666));
      test_done();
   end
endmodule
bind ssfg_top ssfg_top_chk ssfg_top_chk_inst (.*);
